// ### tia_host_cfg.svh
// Offsets, field positions, reset values and preset codes for the switch-matrix host controller.
`ifndef TIA_HOST_CFG_SVH
`define TIA_HOST_CFG_SVH

// Host register offsets on the AHB-Lite slave (byte addresses, one word each).
`define HOST_CMD_OFS 8'h00
`define HOST_SW_DATA_OFS 8'h04
`define HOST_TIA_DATA_OFS 8'h08
`define HOST_DAC_DATA_OFS 8'h0C
`define HOST_STATUS_OFS 8'h10
`define HOST_READBACK_OFS 8'h14
`define HOST_SW_SHADOW_OFS 8'h18
`define HOST_TIA_SHADOW_OFS 8'h1C

// Command register fields.
`define CMD_OP_MSB 3
`define CMD_OP_LSB 0
`define CMD_MODE_MSB 6
`define CMD_MODE_LSB 4

// Command opcodes.
`define OP_WR_SWITCH 4'h0
`define OP_WR_TIA 4'h1
`define OP_RD_SWITCH 4'h2
`define OP_RD_TIA 4'h3
`define OP_PRESET 4'h4
`define OP_EXT_GAIN 4'h5
`define OP_INT_GAIN 4'h6

// Status register bits.
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_REFUSED_BIT 2

// Device register addresses.
`define DEV_SWITCH_ADDR 32'h000020E4
`define DEV_TIA_CTRL_ADDR 32'h000020EC
`define DEV_DAC_CTRL_ADDR 32'h00002128
`define DEV_DAC_SWITCH_ADDR 32'h00002124

// Device register reset values and field positions.
`define DEV_SWITCH_RESET 16'h0000
`define DEV_TIA_CTRL_RESET 32'h00000003
`define SWITCH_USED_BITS 16
`define GAIN_MSB 9
`define GAIN_LSB 5
`define LOAD_MSB 12
`define LOAD_LSB 10
`define EXT_PATH_BIT 9
`define DAC_MODE_BIT 5

// Recommended presets, indexed by the mode field of the command register.
`define PRESET_AMP 16'h302C
`define PRESET_AMP_DIODE 16'h302D
`define PRESET_AMP_SHORT 16'h302E
`define PRESET_ZERO_BIAS 16'h306C
`define PRESET_TWO_LEAD 16'h342C
`define PRESET_LP_PULSE 16'h0014
`define PRESET_FP_PULSE 16'h0094
`define PRESET_UNITY 16'h04A4
`define DAC_SW_LP_PULSE 32'h00000032
`define DAC_SW_FP_PULSE 32'h00000031
`define MODE_LP_PULSE 3'h5
`define MODE_FP_PULSE 3'h6

`endif

// ### tia_host_pkg.sv
// Types shared by the switch-matrix host controller modules.
package tia_host_pkg;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} seq_state_t;

  typedef enum logic [1:0] {LNK_IDLE, LNK_REQ, LNK_REL} link_state_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [31:0] addr;
    logic [31:0] data;
  } dev_op_t;

endpackage

// ### tia_host_if.sv
// Carriers between the bus slave, the command sequencer and the device link.
`timescale 1ns/1ps

interface reg_access_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport bus_side(output wr, output rd, output addr, output wdata, input rdata);
  modport reg_side(input wr, input rd, input addr, input wdata, output rdata);
endinterface

interface dev_cmd_if;
  logic start;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic done;
  modport seq_side(output start, output we, output addr, output wdata, input rdata, input done);
  modport link_side(input start, input we, input addr, input wdata, output rdata, output done);
endinterface

// ### ahb_reg_slave.sv
// AHB-Lite slave front end: writes in the data phase, reads with one wait state.
`timescale 1ns/1ps

module ahb_reg_slave (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  reg_access_if.bus_side regs
);

  logic dph_valid_reg;
  logic dph_write_reg;
  logic [7:0] dph_addr_reg;
  logic rd_done_reg;
  logic rd_wait;

  // Capture the address phase; only word transfers are used, so the size is not decoded.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      dph_valid_reg <= 1'b0;
      dph_write_reg <= 1'b0;
      dph_addr_reg <= 8'h00;
    end else if (i_hready) begin
      dph_valid_reg <= i_hsel & i_htrans[1];
      dph_write_reg <= i_hwrite;
      dph_addr_reg <= {i_haddr[7:2], 2'b00};
    end
  end

  // The read mux is registered before it reaches the bus, costing one wait state.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_done_reg <= 1'b0;
      o_hrdata <= 32'h00000000;
    end else if (rd_wait) begin
      rd_done_reg <= 1'b1;
      o_hrdata <= regs.rdata;
    end else if (o_hreadyout) begin
      rd_done_reg <= 1'b0;
    end
  end

  // Strobes to the register block and the bus answer.
  assign rd_wait = dph_valid_reg & ~dph_write_reg & ~rd_done_reg;
  assign o_hreadyout = ~rd_wait;
  assign o_hresp = 1'b0;
  assign regs.wr = dph_valid_reg & dph_write_reg;
  assign regs.rd = rd_wait;
  assign regs.addr = dph_addr_reg;
  assign regs.wdata = i_hwdata;

endmodule

// ### dev_reg_link.sv
// Four-phase request/acknowledge link to the device's register port.
`timescale 1ns/1ps

module dev_reg_link
  import tia_host_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_dev_ack,
  input wire logic [31:0] i_dev_rdata,
  output logic o_dev_req,
  output logic o_dev_we,
  output logic [31:0] o_dev_addr,
  output logic [31:0] o_dev_wdata,
  dev_cmd_if.link_side cmd
);

  link_state_t state_reg;
  logic ack_meta_reg;
  logic ack_sync_reg;
  logic [31:0] rdata_meta_reg;
  logic [31:0] rdata_sync_reg;
  logic done_reg;
  logic [31:0] rdata_reg;

  // Pins from the device pass two flops before anything looks at them.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
      rdata_meta_reg <= 32'h00000000;
      rdata_sync_reg <= 32'h00000000;
    end else begin
      ack_meta_reg <= i_dev_ack;
      ack_sync_reg <= ack_meta_reg;
      rdata_meta_reg <= i_dev_rdata;
      rdata_sync_reg <= rdata_meta_reg;
    end
  end

  // Request stands until the acknowledge is seen, then drops until the acknowledge clears.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= LNK_IDLE;
      o_dev_req <= 1'b0;
      o_dev_we <= 1'b0;
      o_dev_addr <= 32'h00000000;
      o_dev_wdata <= 32'h00000000;
      done_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        LNK_IDLE: begin
          if (cmd.start && !ack_sync_reg) begin
            o_dev_req <= 1'b1;
            o_dev_we <= cmd.we;
            o_dev_addr <= cmd.addr;
            o_dev_wdata <= cmd.wdata;
            state_reg <= LNK_REQ;
          end
        end
        LNK_REQ: begin
          // The device holds read data steady while it acknowledges.
          if (ack_sync_reg) begin
            o_dev_req <= 1'b0;
            rdata_reg <= rdata_sync_reg;
            state_reg <= LNK_REL;
          end
        end
        LNK_REL: begin
          if (!ack_sync_reg) begin
            done_reg <= 1'b1;
            state_reg <= LNK_IDLE;
          end
        end
        default: begin
          state_reg <= LNK_IDLE;
        end
      endcase
    end
  end

  assign cmd.done = done_reg;
  assign cmd.rdata = rdata_reg;

endmodule

// ### tia_switch_host.sv
// Host controller that programs the loop switch matrix and amplifier control of the front end.
// How it works
// RQ1: Switch register bits 13..0 drive loop switches 13..0 in matching order.
// RQ2: A stored 1 closes a switch, a stored 0 opens it.
// RQ3: Control bits 9..5 select the internal gain resistor.
// RQ4: Control bits 12..10 select the load resistor; large loads borrow gain bank resistors.
// RQ5: For an external gain resistor, write gain field zero to disconnect the internal one.
// RQ6: Close the external path switch, bit 9, only with an external resistor.
// RQ7: Amperometric preset is 0x302C with DAC control bit 5 cleared.
// RQ8: Amperometric with protection diodes is 0x302D.
// RQ9: Amperometric with short protection is 0x302E.
// RQ10: Zero-biased sensor preset is 0x306C.
// RQ11: Two-lead sensor preset is 0x342C.
// RQ12: Low power pulse: DAC bit 5 set, DAC switch 0x32, switch 0x0014.
// RQ13: Full power pulse and voltammetry: DAC bit 5 set, DAC switch 0x31, switch 0x0094.
// RQ14: Unity-gain test: switch 0x04A4 and DAC bit 5 cleared.
// RQ15: Switch register lives at 0x20E4 and resets to zero.
// RQ16: Control register lives at 0x20EC and resets to 0x3.
// RQ17: Bit 15 of the switch register closes switch fifteen when set.
// RQ18: Switch bits 31..16 read zero; bit 14 stores without effect.
// RQ19: A nonzero gain field makes the device close the force/sense switches.
// RQ20: Switch register bit 0 connects the protection diodes across the gain resistor.
`timescale 1ns/1ps
`include "tia_host_cfg.svh"

module tia_switch_host
  import tia_host_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_dev_ack,
  input wire logic [31:0] i_dev_rdata,
  output logic o_dev_req,
  output logic o_dev_we,
  output logic [31:0] o_dev_addr,
  output logic [31:0] o_dev_wdata
);

  reg_access_if regs ();
  dev_cmd_if cmd ();

  logic [15:0] sw_data_reg;
  logic [31:0] tia_data_reg;
  logic [31:0] dac_data_reg;
  logic [15:0] sw_shadow_reg;
  logic [31:0] tia_shadow_reg;
  logic [31:0] readback_reg;
  logic done_flag_reg;
  logic refused_flag_reg;
  seq_state_t state_reg;
  logic [3:0] op_reg;
  logic [2:0] mode_reg;
  logic [1:0] step_reg;
  dev_op_t step_op;
  dev_op_t cur_op_reg;
  logic cmd_wr;
  logic busy;
  logic seq_done;
  logic [31:0] dac_ctrl_word;
  logic mode_dac_bit;

  ahb_reg_slave u_slave (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hwdata(i_hwdata),
    .i_hready(i_hready),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_hrdata(o_hrdata),
    .regs(regs.bus_side)
  );

  dev_reg_link u_link (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_dev_ack(i_dev_ack),
    .i_dev_rdata(i_dev_rdata),
    .o_dev_req(o_dev_req),
    .o_dev_we(o_dev_we),
    .o_dev_addr(o_dev_addr),
    .o_dev_wdata(o_dev_wdata),
    .cmd(cmd.link_side)
  );

  // Switch preset for each measurement mode.
  function automatic logic [15:0] preset_switch(input logic [2:0] mode);
    logic [15:0] val;
    case (mode)
      // RQ7: amperometric preset.
      3'h0: val = `PRESET_AMP;
      // RQ8: protection diodes.
      3'h1: val = `PRESET_AMP_DIODE;
      // RQ9: short protection.
      3'h2: val = `PRESET_AMP_SHORT;
      // RQ10: zero-biased sensor.
      3'h3: val = `PRESET_ZERO_BIAS;
      // RQ11: two-lead sensor.
      3'h4: val = `PRESET_TWO_LEAD;
      // RQ12: low power pulse.
      3'h5: val = `PRESET_LP_PULSE;
      // RQ13: full power pulse.
      3'h6: val = `PRESET_FP_PULSE;
      // RQ14: unity-gain test.
      3'h7: val = `PRESET_UNITY;
      default: val = `DEV_SWITCH_RESET;
    endcase
    return val;
  endfunction

  assign busy = (state_reg != SEQ_IDLE);
  assign cmd_wr = regs.wr && (regs.addr == `HOST_CMD_OFS);
  assign mode_dac_bit = (mode_reg == `MODE_LP_PULSE) || (mode_reg == `MODE_FP_PULSE);

  // Pulse modes hand the bias output to the DAC switch field; the other bits come from software.
  always_comb begin
    dac_ctrl_word = dac_data_reg;
    dac_ctrl_word[`DAC_MODE_BIT] = mode_dac_bit;
  end

  // Device access for the current step; an invalid step ends the command.
  always_comb begin
    step_op = '0;
    case (op_reg)
      `OP_WR_SWITCH: begin
        // RQ1: switch word written as is.
        if (step_reg == 2'd0) begin
          step_op = '{1'b1, 1'b1, `DEV_SWITCH_ADDR, {16'h0000, sw_data_reg}};
        end
      end
      `OP_WR_TIA: begin
        // RQ4: gain and load fields passed through.
        if (step_reg == 2'd0) begin
          step_op = '{1'b1, 1'b1, `DEV_TIA_CTRL_ADDR, tia_data_reg};
        end
      end
      `OP_RD_SWITCH: begin
        if (step_reg == 2'd0) begin
          step_op = '{1'b1, 1'b0, `DEV_SWITCH_ADDR, 32'h00000000};
        end
      end
      `OP_RD_TIA: begin
        if (step_reg == 2'd0) begin
          step_op = '{1'b1, 1'b0, `DEV_TIA_CTRL_ADDR, 32'h00000000};
        end
      end
      `OP_PRESET: begin
        // RQ13: DAC control, then switches, then DAC switch field in pulse modes.
        if (step_reg == 2'd0) begin
          step_op = '{1'b1, 1'b1, `DEV_DAC_CTRL_ADDR, dac_ctrl_word};
        end else if (step_reg == 2'd1) begin
          step_op = '{1'b1, 1'b1, `DEV_SWITCH_ADDR, {16'h0000, preset_switch(mode_reg)}};
        end else if (step_reg == 2'd2 && mode_dac_bit) begin
          step_op = '{1'b1, 1'b1, `DEV_DAC_SWITCH_ADDR,
                      (mode_reg == `MODE_LP_PULSE) ? `DAC_SW_LP_PULSE : `DAC_SW_FP_PULSE};
        end
      end
      `OP_EXT_GAIN: begin
        // RQ5: clear the gain field before closing the external path.
        if (step_reg == 2'd0) begin
          step_op = '{1'b1, 1'b1, `DEV_TIA_CTRL_ADDR, tia_shadow_reg};
          step_op.data[`GAIN_MSB:`GAIN_LSB] = 5'h00;
        end else if (step_reg == 2'd1) begin
          // RQ6: external path switch closed.
          step_op = '{1'b1, 1'b1, `DEV_SWITCH_ADDR, {16'h0000, sw_shadow_reg}};
          step_op.data[`EXT_PATH_BIT] = 1'b1;
        end
      end
      `OP_INT_GAIN: begin
        // RQ6: open the external path before the internal resistor returns.
        if (step_reg == 2'd0) begin
          step_op = '{1'b1, 1'b1, `DEV_SWITCH_ADDR, {16'h0000, sw_shadow_reg}};
          step_op.data[`EXT_PATH_BIT] = 1'b0;
        end else if (step_reg == 2'd1) begin
          // RQ19: a nonzero gain lets the device close force/sense switches.
          step_op = '{1'b1, 1'b1, `DEV_TIA_CTRL_ADDR, tia_data_reg};
        end
      end
      default: begin
        step_op = '0;
      end
    endcase
  end

  assign seq_done = (state_reg == SEQ_ISSUE) && !step_op.valid;

  // Command sequencer: one device access per step, each waiting for the link to finish.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= SEQ_IDLE;
      op_reg <= `OP_WR_SWITCH;
      mode_reg <= 3'h0;
      step_reg <= 2'd0;
      cur_op_reg <= '0;
    end else begin
      case (state_reg)
        SEQ_IDLE: begin
          if (cmd_wr) begin
            op_reg <= regs.wdata[`CMD_OP_MSB:`CMD_OP_LSB];
            mode_reg <= regs.wdata[`CMD_MODE_MSB:`CMD_MODE_LSB];
            step_reg <= 2'd0;
            state_reg <= SEQ_ISSUE;
          end
        end
        SEQ_ISSUE: begin
          if (step_op.valid) begin
            cur_op_reg <= step_op;
            state_reg <= SEQ_WAIT;
          end else begin
            state_reg <= SEQ_IDLE;
          end
        end
        SEQ_WAIT: begin
          if (cmd.done) begin
            step_reg <= step_reg + 2'd1;
            state_reg <= SEQ_ISSUE;
          end
        end
        default: begin
          state_reg <= SEQ_IDLE;
        end
      endcase
    end
  end

  // The link starts when the sequencer enters the wait state with a fresh access.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd.start <= 1'b0;
    end else begin
      cmd.start <= (state_reg == SEQ_ISSUE) && step_op.valid;
    end
  end
  assign cmd.we = cur_op_reg.we;
  assign cmd.addr = cur_op_reg.addr;
  assign cmd.wdata = cur_op_reg.data;

  // Shadows mirror what the device holds; unused switch bits are dropped.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      // RQ15: switches all open after reset.
      sw_shadow_reg <= `DEV_SWITCH_RESET;
      // RQ16: control register reset value.
      tia_shadow_reg <= `DEV_TIA_CTRL_RESET;
      readback_reg <= 32'h00000000;
    end else if (state_reg == SEQ_WAIT && cmd.done) begin
      if (!cur_op_reg.we) begin
        readback_reg <= cmd.rdata;
      end
      // RQ18: bits above 15 are never kept.
      if (cur_op_reg.addr == `DEV_SWITCH_ADDR) begin
        sw_shadow_reg <= cur_op_reg.we ? cur_op_reg.data[15:0] : cmd.rdata[15:0];
      end else if (cur_op_reg.addr == `DEV_TIA_CTRL_ADDR) begin
        tia_shadow_reg <= cur_op_reg.we ? cur_op_reg.data : cmd.rdata;
      end
    end
  end

  // Software data registers; switch data keeps bit 15 and bit 14 as written.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sw_data_reg <= `DEV_SWITCH_RESET;
      tia_data_reg <= `DEV_TIA_CTRL_RESET;
      dac_data_reg <= 32'h00000000;
    end else if (regs.wr) begin
      // RQ17: bit 15 stored with the rest.
      if (regs.addr == `HOST_SW_DATA_OFS) begin
        sw_data_reg <= regs.wdata[15:0];
      end
      if (regs.addr == `HOST_TIA_DATA_OFS) begin
        tia_data_reg <= regs.wdata;
      end
      if (regs.addr == `HOST_DAC_DATA_OFS) begin
        dac_data_reg <= regs.wdata;
      end
    end
  end

  // Sticky flags clear on a write of one; a completion in the same cycle still sets.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      done_flag_reg <= 1'b0;
      refused_flag_reg <= 1'b0;
    end else begin
      if (seq_done) begin
        done_flag_reg <= 1'b1;
      end else if (regs.wr && regs.addr == `HOST_STATUS_OFS && regs.wdata[`STAT_DONE_BIT]) begin
        done_flag_reg <= 1'b0;
      end
      if (cmd_wr && busy) begin
        refused_flag_reg <= 1'b1;
      end else if (regs.wr && regs.addr == `HOST_STATUS_OFS &&
                   regs.wdata[`STAT_REFUSED_BIT]) begin
        refused_flag_reg <= 1'b0;
      end
    end
  end

  // Read mux; unmapped offsets read zero.
  always_comb begin
    regs.rdata = 32'h00000000;
    case (regs.addr)
      `HOST_CMD_OFS: regs.rdata = {25'h0, mode_reg, op_reg};
      `HOST_SW_DATA_OFS: regs.rdata = {16'h0000, sw_data_reg};
      `HOST_TIA_DATA_OFS: regs.rdata = tia_data_reg;
      `HOST_DAC_DATA_OFS: regs.rdata = dac_data_reg;
      `HOST_STATUS_OFS: regs.rdata = {29'h0, refused_flag_reg, done_flag_reg, busy};
      `HOST_READBACK_OFS: regs.rdata = readback_reg;
      `HOST_SW_SHADOW_OFS: regs.rdata = {16'h0000, sw_shadow_reg};
      `HOST_TIA_SHADOW_OFS: regs.rdata = tia_shadow_reg;
      default: regs.rdata = 32'h00000000;
    endcase
  end

endmodule

// ### tia_switch_host_sva.sv
// Concurrent checks on the host controller's bus and device-link ports.
`timescale 1ns/1ps
`include "tia_host_cfg.svh"

module tia_switch_host_sva (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic i_dev_ack,
  input wire logic [31:0] i_dev_rdata,
  input wire logic o_dev_req,
  input wire logic o_dev_we,
  input wire logic [31:0] o_dev_addr,
  input wire logic [31:0] o_dev_wdata
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_rd_addr;
    i_hsel && i_htrans[1] && !i_hwrite && i_hready;
  endsequence
  sequence s_wr_addr;
    i_hsel && i_htrans[1] && i_hwrite && i_hready;
  endsequence
  sequence s_one_wait;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  property p_read_wait;
    s_rd_addr |=> s_one_wait;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("Read without one wait state.");
  property p_write_nowait;
    s_wr_addr |=> o_hreadyout;
  endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("Write data phase stalled.");
  property p_okay;
    o_hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("Response is not OKAY.");
  property p_req_hold;
    o_dev_req && !i_dev_ack |=> o_dev_req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("Request dropped before ack.");
  property p_req_stable;
    o_dev_req && $past(o_dev_req) |->
      $stable(o_dev_addr) && $stable(o_dev_wdata) && $stable(o_dev_we);
  endproperty
  a_req_stable: assert property (p_req_stable) else $error("Access changed under request.");
  property p_req_drop;
    $rose(i_dev_ack) |-> ##[2:3] !o_dev_req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("Request not released after ack.");
  property p_addr_map;
    o_dev_req |-> o_dev_addr inside {`DEV_SWITCH_ADDR, `DEV_TIA_CTRL_ADDR,
      `DEV_DAC_CTRL_ADDR, `DEV_DAC_SWITCH_ADDR};
  endproperty
  a_addr_map: assert property (p_addr_map) else $error("Device address off the map.");
  property p_sw_upper;
    o_dev_req && o_dev_we && o_dev_addr == `DEV_SWITCH_ADDR |-> o_dev_wdata[31:16] == 16'h0000;
  endproperty
  a_sw_upper: assert property (p_sw_upper) else $error("Reserved switch bits written.");
endmodule

bind tia_switch_host tia_switch_host_sva u_sva (.i_sys_clk, .i_rst, .i_hsel, .i_haddr, .i_htrans,
  .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_hrdata, .i_dev_ack,
  .i_dev_rdata, .o_dev_req, .o_dev_we, .o_dev_addr, .o_dev_wdata);

// ### tia_dev_model.sv
// Behavioural front-end device: four-phase register port over a small register table.
`timescale 1ns/1ps

module tia_dev_model (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_slow,
  output logic o_ack,
  output logic [31:0] o_rdata,
  output logic [15:0] o_sw,
  output logic [31:0] o_ctrl,
  output logic [31:0] o_dac,
  output logic [31:0] o_dac_sw
);
  logic [2:0] cnt_reg;
  logic [31:0] rd;
  // Read mux; only sixteen switch bits are stored.
  // reserved read zero
  always_comb begin
    case (i_addr)
      32'h000020E4: rd = {16'h0000, o_sw};
      32'h000020EC: rd = o_ctrl;
      32'h00002128: rd = o_dac;
      32'h00002124: rd = o_dac_sw;
      default: rd = 32'h00000000;
    endcase
  end
  // Data settles one cycle before ack, six with i_slow set; once released it toggles so stale reads show up.
  // reset values
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      o_rdata <= 32'h00000000;
      cnt_reg <= 3'h0;
      o_sw <= 16'h0000;
      o_ctrl <= 32'h00000003;
      o_dac <= 32'h00000000;
      o_dac_sw <= 32'h00000000;
    end else if (i_req != o_ack) begin
      o_rdata <= i_req ? rd : ~o_rdata;
      cnt_reg <= cnt_reg + 3'h1;
      if (cnt_reg >= (i_slow ? 3'h6 : 3'h1)) begin
        cnt_reg <= 3'h0;
        o_ack <= i_req;
        if (i_req && i_we && i_addr == 32'h000020E4) o_sw <= i_wdata[15:0];
        if (i_req && i_we && i_addr == 32'h000020EC) o_ctrl <= i_wdata;
        if (i_req && i_we && i_addr == 32'h00002128) o_dac <= i_wdata;
        if (i_req && i_we && i_addr == 32'h00002124) o_dac_sw <= i_wdata;
      end
    end
  end
endmodule

// ### tia_switch_host_bench.sv
// Self-checking bench for the switch-matrix host controller.
`timescale 1ns/1ps
`include "tia_host_cfg.svh"

module tia_switch_host_bench;
  logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, dev_ack, dev_req, dev_we, slow;
  logic [31:0] haddr, hwdata, hrdata, dev_rdata, dev_addr, dev_wdata, ctrl, dac, dac_sw, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] sw;
  int failures, checked;

  tia_switch_host uut (.i_sys_clk(sys_clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_dev_ack(dev_ack), .i_dev_rdata(dev_rdata), .o_dev_req(dev_req), .o_dev_we(dev_we),
    .o_dev_addr(dev_addr), .o_dev_wdata(dev_wdata));
  tia_dev_model dev (.i_sys_clk(sys_clk), .i_rst(rst), .i_req(dev_req), .i_we(dev_we),
    .i_addr(dev_addr), .i_wdata(dev_wdata), .i_slow(slow), .o_ack(dev_ack),
    .o_rdata(dev_rdata), .o_sw(sw), .o_ctrl(ctrl), .o_dac(dac), .o_dac_sw(dac_sw));

  task automatic close_out();
    $display("Counts: %0d checked, %0d failures", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask
  // Ready and read data are taken at the rising edge, before the design updates.
  task automatic wait_rdy(output logic [31:0] rd);
    for (int n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (hreadyout === 1'b1) begin
        rd = hrdata;
        return;
      end
    end
    failures++;
    close_out();
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy(x);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(d);
  endtask
  // Polls status; a command must finish with done set and busy clear.
  task automatic wait_done();
    for (int n = 0; n < 400; n++) begin
      ahb(1'b0, `HOST_STATUS_OFS, 32'h0);
      if (d[1] === 1'b1 && d[0] === 1'b0) return;
    end
    failures++;
    close_out();
  endtask
  task automatic run_cmd(input logic [3:0] op, input logic [2:0] mode);
    ahb(1'b1, `HOST_STATUS_OFS, 32'h00000006);
    ahb(1'b1, `HOST_CMD_OFS, {25'h0, mode, op});
    wait_done();
  endtask
  task automatic t_reset();
    ahb(1'b0, `HOST_TIA_DATA_OFS, 32'h0);
    chk("tia_data", d, 32'h00000003);
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", d, 32'h00000000);
    run_cmd(`OP_RD_SWITCH, 3'h0);
    ahb(1'b0, `HOST_READBACK_OFS, 32'h0);
    chk("switch_reset", d, 32'h00000000);
    run_cmd(`OP_RD_TIA, 3'h0);
    ahb(1'b0, `HOST_READBACK_OFS, 32'h0);
    chk("control_reset", d, 32'h00000003);
    $display("t_reset finished");
  endtask
  task automatic t_switch();
    logic [15:0] v[3] = '{16'hC001, 16'h3FFE, 16'h0000};
    foreach (v[i]) begin
      ahb(1'b1, `HOST_SW_DATA_OFS, {16'hFFFF, v[i]});
      run_cmd(`OP_WR_SWITCH, 3'h0);
      chk("switch_lines", {16'h0, sw}, {16'h0, v[i]});
      run_cmd(`OP_RD_SWITCH, 3'h0);
      ahb(1'b0, `HOST_READBACK_OFS, 32'h0);
      chk("switch_read", d, {16'h0, v[i]});
    end
    $display("t_switch finished");
  endtask
  task automatic t_presets();
    logic [15:0] pre[8] = '{16'h302C, 16'h302D, 16'h302E, 16'h306C, 16'h342C, 16'h0014,
      16'h0094, 16'h04A4};
    ahb(1'b1, `HOST_DAC_DATA_OFS, 32'h00000021);
    for (int m = 0; m < 8; m++) begin
      run_cmd(`OP_PRESET, m[2:0]);
      chk("preset_switch", {16'h0, sw}, {16'h0, pre[m]});
      chk("preset_dac", dac, (m == 5 || m == 6) ? 32'h21 : 32'h01);
      if (m == 5 || m == 6) chk("dac_switch", dac_sw, (m == 5) ? 32'h32 : 32'h31);
    end
    $display("t_presets finished");
  endtask
  task automatic t_gain();
    ahb(1'b1, `HOST_TIA_DATA_OFS, 32'h00001C63);
    run_cmd(`OP_WR_TIA, 3'h0);
    chk("control", ctrl, 32'h00001C63);
    run_cmd(`OP_PRESET, 3'h0);
    run_cmd(`OP_RD_SWITCH, 3'h0);
    run_cmd(`OP_RD_TIA, 3'h0);
    run_cmd(`OP_EXT_GAIN, 3'h0);
    chk("ext_gain", ctrl, 32'h00001C03);
    chk("ext_path", {16'h0, sw}, 32'h0000322C);
    run_cmd(`OP_INT_GAIN, 3'h0);
    chk("int_path", {16'h0, sw}, 32'h0000302C);
    chk("int_gain", ctrl, 32'h00001C63);
    $display("t_gain finished");
  endtask
  task automatic t_busy();
    slow <= 1'b1;
    ahb(1'b1, `HOST_STATUS_OFS, 32'h00000006);
    ahb(1'b1, `HOST_CMD_OFS, {28'h0, `OP_RD_SWITCH});
    ahb(1'b1, `HOST_TIA_DATA_OFS, 32'h00000003);
    ahb(1'b1, `HOST_CMD_OFS, {28'h0, `OP_WR_TIA});
    ahb(1'b0, `HOST_STATUS_OFS, 32'h0);
    chk("busy_refused", d & 32'h5, 32'h00000005);
    wait_done();
    chk("refused_kept", ctrl, 32'h00001C63);
    slow <= 1'b0;
    $display("t_busy finished");
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    slow = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_switch();
    t_presets();
    t_gain();
    t_busy();
    close_out();
  end
endmodule
